// file: rtl/bkr_pkg.sv
/*
  Constants for the backup register bank: register offsets, field
  positions, field masks and reset values. Assumes a 32-bit APB with byte
  addresses, each register in one aligned word.
*/
package bkr_pkg;
  // Bus and storage shape
  localparam int BKR_DATA_WORDS = 42;
  localparam int BKR_REG_W = 16;
  localparam int BKR_RTC_DIV = 64;

  // Register offsets (byte addresses)
  localparam logic [7:0] BKR_DATA_LO_FIRST = 8'h04;
  localparam logic [7:0] BKR_DATA_LO_LAST = 8'h28;
  localparam logic [7:0] BKR_OUT_CTL_OFS = 8'h2c;
  localparam logic [7:0] BKR_PIN_CTL_OFS = 8'h30;
  localparam logic [7:0] BKR_TAMP_CS_OFS = 8'h34;
  localparam logic [7:0] BKR_DATA_HI_FIRST = 8'h40;
  localparam logic [7:0] BKR_DATA_HI_LAST = 8'hbc;

  // Output control fields
  localparam int BKR_CAL_VALUE_LSB = 0;
  localparam int BKR_CAL_VALUE_W = 7;
  localparam int BKR_CAL_OUT_ENABLE_BIT = 7;
  localparam int BKR_ALARM_SECOND_OUT_ENABLE_BIT = 8;
  localparam int BKR_RTC_OUT_SELECT_BIT = 9;
  localparam int BKR_CAL_CLOCK_OUT_SELECT_BIT = 14;
  localparam int BKR_CAL_DIRECTION_BIT = 15;
  // Fields cleared by the backup-domain reset only
  localparam logic [15:0] BKR_OUT_BKP_MASK = 16'h837f;
  // Fields cleared by the power-on reset only
  localparam logic [15:0] BKR_OUT_POR_MASK = 16'h4080;

  // Tamper pin control fields
  localparam int BKR_TAMPER_DETECT_ENABLE_BIT = 0;
  localparam int BKR_TAMPER_LEVEL_BIT = 1;
  localparam logic [15:0] BKR_PIN_CTL_MASK = 16'h0003;

  // Tamper control and status fields
  localparam int BKR_TAMPER_EVENT_CLEAR_BIT = 0;
  localparam int BKR_TAMPER_IRQ_CLEAR_BIT = 1;
  localparam int BKR_TAMPER_IRQ_ENABLE_BIT = 2;
  localparam int BKR_TAMPER_EVENT_FLAG_BIT = 8;
  localparam int BKR_TAMPER_IRQ_FLAG_BIT = 9;

  // Reset values
  localparam logic [15:0] BKR_DATA_RST = 16'h0000;
  localparam logic [15:0] BKR_CTL_RST = 16'h0000;
endpackage

// file: rtl/bkr_bank.sv
/*
  Backup register bank with tamper detection and RTC signal output on the
  shared tamper pin, reached over APB (zero wait states).
  Assumes: all inputs synchronous to ref_clk_i except the tamper pin and
  the RTC signals, which are synchronised here; the three resets are
  synchronous, active high, and come from the system reset controller.
*/
// How it works
// R1 - Forty-two 16-bit read/write data words, reset to zero.
// R2 - Data words survive standby, system and power reset.
// R3 - Half-word and word accesses act alike on the 16 defined bits.
// R4 - Seven-bit calibration value and direction bit go to the RTC.
// R5 - Calibration output drives RTC clock divided by 64, or undivided.
// R6 - Signal output drives alarm pulse or second pulse, chosen by select.
// R7 - Alarm/second output wins over the calibration clock output.
// R8 - Direction, select, signal enable and value: backup reset only.
// R9 - Clock select and calibration output enable: power-on reset only.
// R10 - Tamper level bit chooses active high (0) or active low (1).
// R11 - Enabled detection at the active level erases all data words.
// R12 - Event flag set on tamper, cleared by writing one to event clear.
// R13 - Interrupt flag cleared by its clear bit or while enable is zero.
// R14 - Clear bits are write-only strobes that read as zero.
// R15 - Interrupt enable cleared by system reset and standby wake-up.
// R16 - Edge detect gated by enable; enabling while active gives one event.
// R17 - Writes are blocked unless the backup write enable is set.
// R18 - Tamper raises interrupt flag only when interrupt enable is set.
// R19 - Reserved bits read zero and ignore writes.
// R20 - Pin and RTC signals synchronised, so each event sets flags once.
`timescale 1ns/1ps
`default_nettype none

module bkr_bank #(
  parameter int ADDR_W = 8,
  parameter int RTC_DIV = bkr_pkg::BKR_RTC_DIV
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bkp_rst_i,
  input wire logic por_rst_i,
  input wire logic stby_wake_i,
  input wire logic backup_write_enable_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tamper_pin_i,
  output logic tamper_pin_o,
  output logic tamper_pin_oe_o,
  input wire logic rtc_clk_i,
  input wire logic rtc_alarm_i,
  input wire logic rtc_second_i,
  output logic [bkr_pkg::BKR_CAL_VALUE_W-1:0] cal_value_o,
  output logic cal_direction_o,
  output logic tamper_event_o,
  output logic tamper_irq_o
);
  import bkr_pkg::*;

  localparam int DIV_HALF = RTC_DIV / 2;
  localparam int CNT_W = $clog2(DIV_HALF) + 1;

  // Map lies in the low eight address bits; decode requires all upper address bits zero
  if (ADDR_W < 8) begin : g_bad_addr
    $error("bkr_bank: ADDR_W must be at least 8");
  end
  if (RTC_DIV < 2 || (RTC_DIV % 2) != 0) begin : g_bad_div
    $error("bkr_bank: RTC_DIV must be even and at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Word address to data word index; bit 6 flags a hit
  function automatic logic [6:0] word_index(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    logic [5:0] w;
    logic upper_zero;
    lo = a[7:0];
    w = lo[7:2];
    upper_zero = (a >> 8) == '0;
    word_index = 7'h00;
    if (upper_zero && lo >= BKR_DATA_LO_FIRST && lo <= BKR_DATA_LO_LAST) begin
      word_index = {1'b1, 6'(w - 6'h01)};
    end else if (upper_zero && lo >= BKR_DATA_HI_FIRST
                 && lo <= BKR_DATA_HI_LAST) begin
      word_index = {1'b1, 6'(w - 6'h06)};
    end
  endfunction

  // Byte-lane merge of a 16-bit register; bits outside mask keep old value
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    lane_merge = (old & ~lanes) | (wd[15:0] & lanes);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] data_ff [BKR_DATA_WORDS];
  logic [15:0] out_bkp_ff;
  logic [15:0] out_por_ff;
  logic [1:0] pin_ctl_ff;
  logic tamper_irq_enable_ff;
  logic tef_ff;
  logic tif_ff;
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic gated_d_ff;
  logic rtc_clk_d_ff;
  logic [CNT_W-1:0] div_cnt_ff;
  logic div_clk_ff;
  logic pin_out_ff;
  logic [31:0] prdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [6:0] hit_idx;
  logic data_hit;
  logic [5:0] data_idx;
  logic out_hit;
  logic pin_hit;
  logic cs_hit;
  logic any_hit;
  logic bus_wr;
  logic reg_wr;
  logic lane_any;

  assign hit_idx = word_index(paddr);
  assign data_hit = hit_idx[6];
  assign data_idx = hit_idx[5:0];
  assign out_hit = paddr == ADDR_W'(BKR_OUT_CTL_OFS);
  assign pin_hit = paddr == ADDR_W'(BKR_PIN_CTL_OFS);
  assign cs_hit = paddr == ADDR_W'(BKR_TAMP_CS_OFS);
  assign any_hit = data_hit | out_hit | pin_hit | cs_hit;
  assign bus_wr = psel & penable & pwrite;
  assign lane_any = pstrb[0] | pstrb[1];
  // R17 write gate
  assign reg_wr = bus_wr & backup_write_enable_i;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~any_hit;

  ////////////////////////////////////////////////////////////////////////
  // Tamper detection

  logic pin_s;
  logic rtc_clk_s;
  logic alarm_s;
  logic second_s;
  logic act_s;
  logic gated;
  logic tamper_event;

  // R20 two-stage synchronisers for pin and RTC signals
  // Backup domain: a system reset must not make an active pin look new
  always_ff @(posedge ref_clk_i) begin
    if (bkp_rst_i) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end else begin
      meta_ff <= {rtc_second_i, rtc_alarm_i, rtc_clk_i, tamper_pin_i};
      sync_ff <= meta_ff;
    end
  end

  assign pin_s = sync_ff[0];
  assign rtc_clk_s = sync_ff[1];
  assign alarm_s = sync_ff[2];
  assign second_s = sync_ff[3];

  // R10 active level select
  assign act_s = pin_s ^ pin_ctl_ff[BKR_TAMPER_LEVEL_BIT];
  // R16 edge of the enable-gated level, so enabling while active counts
  assign gated = act_s & pin_ctl_ff[BKR_TAMPER_DETECT_ENABLE_BIT];
  assign tamper_event = gated & ~gated_d_ff;
  assign tamper_event_o = tamper_event;

  // Edge state kept over system reset, so no false event erases the data
  always_ff @(posedge ref_clk_i) begin
    if (bkp_rst_i) begin
      gated_d_ff <= 1'b0;
    end else begin
      gated_d_ff <= gated;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data words

  logic data_wr;
  assign data_wr = reg_wr & data_hit & lane_any;

  // R2 only backup reset or tamper clears; R11 tamper erase wins over write
  always_ff @(posedge ref_clk_i) begin
    if (bkp_rst_i || tamper_event) begin
      for (int i = 0; i < BKR_DATA_WORDS; i++) begin
        data_ff[i] <= BKR_DATA_RST;
      end
    end else if (data_wr) begin
      // R1 R3 lane-wise write
      data_ff[data_idx] <= lane_merge(data_ff[data_idx], pwdata, pstrb,
                                      16'hffff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [15:0] nxt_out_bkp;
  logic [15:0] nxt_out_por;
  logic [15:0] nxt_pin_ctl;
  logic cs_wr;
  logic cs_wr0;
  logic ter_wr;
  logic tir_wr;

  // R8 R9 R19 split by reset domain, reserved bits masked off
  assign nxt_out_bkp = lane_merge(out_bkp_ff, pwdata, pstrb,
                                  BKR_OUT_BKP_MASK);
  assign nxt_out_por = lane_merge(out_por_ff, pwdata, pstrb,
                                  BKR_OUT_POR_MASK);
  assign nxt_pin_ctl = lane_merge({14'h0000, pin_ctl_ff}, pwdata, pstrb,
                                  BKR_PIN_CTL_MASK);
  assign cs_wr = reg_wr & cs_hit;
  assign cs_wr0 = cs_wr & pstrb[0];
  // R14 clear strobes act only on a written one
  assign ter_wr = cs_wr0 & pwdata[BKR_TAMPER_EVENT_CLEAR_BIT];
  assign tir_wr = cs_wr0 & pwdata[BKR_TAMPER_IRQ_CLEAR_BIT];

  // R8 backup-domain fields
  always_ff @(posedge ref_clk_i) begin
    if (bkp_rst_i) begin
      out_bkp_ff <= BKR_CTL_RST;
    end else if (reg_wr && out_hit) begin
      out_bkp_ff <= nxt_out_bkp;
    end
  end

  // R9 power-on fields
  always_ff @(posedge ref_clk_i) begin
    if (por_rst_i) begin
      out_por_ff <= BKR_CTL_RST;
    end else if (reg_wr && out_hit) begin
      out_por_ff <= nxt_out_por;
    end
  end

  // Pin control lives in the backup domain so detection survives system and power-on resets
  always_ff @(posedge ref_clk_i) begin
    if (bkp_rst_i) begin
      pin_ctl_ff <= BKR_CTL_RST[1:0];
    end else if (reg_wr && pin_hit) begin
      pin_ctl_ff <= nxt_pin_ctl[1:0];
    end
  end

  // R15 interrupt enable cleared by system reset and standby wake-up
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || stby_wake_i) begin
      tamper_irq_enable_ff <= BKR_CTL_RST[BKR_TAMPER_IRQ_ENABLE_BIT];
    end else if (cs_wr0) begin
      tamper_irq_enable_ff <= pwdata[BKR_TAMPER_IRQ_ENABLE_BIT];
    end
  end

  // R12 R13 R18 flags; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (bkp_rst_i) begin
      tef_ff <= 1'b0;
      tif_ff <= 1'b0;
    end else begin
      tef_ff <= tamper_event | (tef_ff & ~ter_wr);
      tif_ff <= tamper_irq_enable_ff & (tamper_event | (tif_ff & ~tir_wr));
    end
  end

  assign tamper_irq_o = tif_ff;

  // R4 calibration value and direction toward the RTC counter
  assign cal_value_o = out_bkp_ff[BKR_CAL_VALUE_LSB +: BKR_CAL_VALUE_W];
  assign cal_direction_o = out_bkp_ff[BKR_CAL_DIRECTION_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Tamper pin output

  logic alarm_second_out_enable;
  logic cal_out_enable;
  logic rtc_rise;
  logic div_wrap;
  logic nxt_pin_out;

  assign alarm_second_out_enable = out_bkp_ff[BKR_ALARM_SECOND_OUT_ENABLE_BIT];
  assign cal_out_enable = out_por_ff[BKR_CAL_OUT_ENABLE_BIT];
  assign rtc_rise = rtc_clk_s & ~rtc_clk_d_ff;
  assign div_wrap = div_cnt_ff == CNT_W'(DIV_HALF - 1);

  // R5 divider: toggle every half period of RTC_DIV rising edges
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rtc_clk_d_ff <= 1'b0;
      div_cnt_ff <= '0;
      div_clk_ff <= 1'b0;
    end else begin
      rtc_clk_d_ff <= rtc_clk_s;
      if (rtc_rise) begin
        div_cnt_ff <= div_wrap ? '0 : CNT_W'(div_cnt_ff + 1'b1);
        div_clk_ff <= div_clk_ff ^ div_wrap;
      end
    end
  end

  // R5 R6 R7 alarm/second wins, then undivided or divided clock
  assign nxt_pin_out = alarm_second_out_enable
      ? (out_bkp_ff[BKR_RTC_OUT_SELECT_BIT] ? second_s : alarm_s)
      : (out_por_ff[BKR_CAL_CLOCK_OUT_SELECT_BIT] ? rtc_clk_s : div_clk_ff);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_out_ff <= 1'b0;
    end else begin
      pin_out_ff <= nxt_pin_out;
    end
  end

  // R11 detection owns the pin, so the driver stays off while it is enabled
  assign tamper_pin_o = pin_out_ff;
  assign tamper_pin_oe_o = (alarm_second_out_enable | cal_out_enable)
      & ~pin_ctl_ff[BKR_TAMPER_DETECT_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Read path

  logic [15:0] cs_rd;
  logic [15:0] rd_val;
  logic setup;

  // R14 R19 clear strobes and reserved bits read as zero
  assign cs_rd = (16'(tif_ff) << BKR_TAMPER_IRQ_FLAG_BIT)
      | (16'(tef_ff) << BKR_TAMPER_EVENT_FLAG_BIT)
      | (16'(tamper_irq_enable_ff) << BKR_TAMPER_IRQ_ENABLE_BIT);
  assign rd_val = data_hit ? data_ff[data_idx]
      : out_hit ? (out_bkp_ff | out_por_ff)
      : pin_hit ? {14'h0000, pin_ctl_ff}
      : cs_hit ? cs_rd
      : 16'h0000;
  assign setup = psel & ~penable;

  // Read data is captured in the setup cycle and held through access
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= {16'h0000, rd_val};
    end
  end

  assign prdata = prdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i || bkp_rst_i || por_rst_i);

  sequence s_enable_while_active;
    !pin_ctl_ff[BKR_TAMPER_DETECT_ENABLE_BIT]
    ##1 (pin_ctl_ff[BKR_TAMPER_DETECT_ENABLE_BIT] && act_s);
  endsequence

  sequence s_blocked_data_write;
    psel && penable && pwrite && !backup_write_enable_i
    && data_hit && data_idx == 6'h00 && !tamper_event;
  endsequence

  a_event_sets_flag: assert property ( // R12
    tamper_event |=> tef_ff && tamper_event_o == 1'b0)
    else $error("tamper event did not set the event flag");

  a_event_erases_data: assert property ( // R11
    tamper_event |=> data_ff[0] == 16'h0000 && data_ff[41] == 16'h0000)
    else $error("tamper event left data words set");

  a_irq_needs_enable: assert property ( // R13
    !tamper_irq_enable_ff |=> !tif_ff)
    else $error("interrupt flag set while enable was zero");

  a_irq_follows_event: assert property ( // R18
    tamper_event && tamper_irq_enable_ff |=> tif_ff && tamper_irq_o)
    else $error("enabled tamper event did not raise interrupt flag");

  a_enable_extra_event: assert property ( // R16
    s_enable_while_active |-> tamper_event)
    else $error("enabling at active level gave no event");

  a_event_once: assert property ( // R20
    tamper_event |=> !tamper_event)
    else $error("one tamper edge gave two events");

  a_clear_reads_zero: assert property ( // R14
    setup && cs_hit |=> prdata[1:0] == 2'b00 && prdata[7:3] == 5'h00)
    else $error("clear strobe or reserved bit read as one");

  a_write_blocked: assert property ( // R17
    s_blocked_data_write |=> $stable(data_ff[0]))
    else $error("data word changed with backup writes disabled");

  a_alarm_priority: assert property ( // R7
    alarm_second_out_enable && !out_bkp_ff[BKR_RTC_OUT_SELECT_BIT]
    |=> tamper_pin_o == $past(alarm_s))
    else $error("pin did not carry the alarm pulse");

  a_undivided_clock: assert property ( // R5
    !alarm_second_out_enable && out_por_ff[BKR_CAL_CLOCK_OUT_SELECT_BIT]
    |=> tamper_pin_o == $past(rtc_clk_s))
    else $error("pin did not carry the undivided RTC clock");
endmodule

`default_nettype wire

// file: test/backup_regs_tamper_rtc_out_test.sv
/*
  Self-checking bench for the backup register bank. It covers register
  access over APB, the reset domains, the RTC signal output on the pin and
  tamper detection.
  Assumes the bank answers APB through pready, and that the pin and RTC
  inputs are synchronised inside the bank.
*/
`timescale 1ns/1ps
`default_nettype none

module backup_regs_tamper_rtc_out_test;
  import bkr_pkg::*;

  // Small divider keeps the divided-clock run short
  localparam int DIV = 4;

  logic ref_clk_i = 1'b0;
  logic rst_i, bkp_rst_i, por_rst_i, stby_wake_i, backup_write_enable_i;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic tamper_pin_i, tamper_pin_o, tamper_pin_oe_o;
  logic rtc_clk_i, rtc_alarm_i, rtc_second_i;
  logic [6:0] cal_value_o;
  logic cal_direction_o, tamper_event_o, tamper_irq_o;
  int mismatches = 0;
  int check_count = 0;
  int tog;

  always #20 ref_clk_i = ~ref_clk_i;

  bkr_bank #(.ADDR_W(8), .RTC_DIV(DIV)) bkr_bank_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bkp_rst_i(bkp_rst_i),
    .por_rst_i(por_rst_i), .stby_wake_i(stby_wake_i),
    .backup_write_enable_i(backup_write_enable_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tamper_pin_i(tamper_pin_i),
    .tamper_pin_o(tamper_pin_o), .tamper_pin_oe_o(tamper_pin_oe_o),
    .rtc_clk_i(rtc_clk_i), .rtc_alarm_i(rtc_alarm_i),
    .rtc_second_i(rtc_second_i), .cal_value_o(cal_value_o),
    .cal_direction_o(cal_direction_o), .tamper_event_o(tamper_event_o),
    .tamper_irq_o(tamper_irq_o));

  ////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Bounded wait for pready (k=0) or the tamper event pulse (k=1)
  task automatic wait_for(input int k);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    while (((k == 1) ? tamper_event_o : pready) !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        final_report();
      end
      @(posedge ref_clk_i);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // APB master: request held until the edge that samples pready high
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    wait_for(0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'hf);
  endtask

  // Read one register and compare the whole word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0, 4'h0);
    chk(rd, exp);
  endtask

  function automatic logic [7:0] ofs(input int i);
    if (i < 10) begin
      return BKR_DATA_LO_FIRST + 8'(4 * i);
    end
    return BKR_DATA_HI_FIRST + 8'(4 * (i - 10));
  endfunction

  function automatic logic [31:0] dv(input int i);
    return {16'h0, 16'ha5c3 ^ 16'(i * 1031)};
  endfunction

  // Sixteen RTC clock periods; counts every change seen on the pin
  task automatic run_rtc(output int t);
    logic last;
    t = 0;
    last = tamper_pin_o;
    for (int i = 0; i < 140; i++) begin
      rtc_clk_i <= (i < 128) & i[2];
      @(posedge ref_clk_i);
      if (tamper_pin_o !== last) t++;
      last = tamper_pin_o;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_i, bkp_rst_i, por_rst_i} = 3'b111;
    {stby_wake_i, backup_write_enable_i, psel, penable, pwrite} = 5'b0;
    {tamper_pin_i, rtc_clk_i, rtc_alarm_i, rtc_second_i} = 4'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    cyc(5);
    {rst_i, bkp_rst_i, por_rst_i} <= 3'b000;
    rdchk(ofs(0), 32'h0);
    rdchk(BKR_OUT_CTL_OFS, 32'h0);
    rdchk(BKR_PIN_CTL_OFS, 32'h0);
    rdchk(BKR_TAMP_CS_OFS, 32'h0);
    wr(ofs(0), 32'h1234);
    rdchk(ofs(0), 32'h0);
    backup_write_enable_i <= 1'b1;
    for (int i = 0; i < 42; i++) wr(ofs(i), dv(i) | 32'hffff0000);
    for (int i = 0; i < 42; i++) rdchk(ofs(i), dv(i));
    xfer(ofs(1), 1'b1, 32'hffff5a5a, 4'h3);
    rdchk(ofs(1), 32'h5a5a);
    xfer(ofs(2), 1'b1, 32'h0000ffff, 4'h0);
    rdchk(ofs(2), dv(2));
    xfer(8'h38, 1'b0, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    wr(BKR_PIN_CTL_OFS, 32'hffff0000);
    rdchk(BKR_PIN_CTL_OFS, 32'h0);
    wr(BKR_OUT_CTL_OFS, 32'hffffffff);
    rdchk(BKR_OUT_CTL_OFS, 32'hc3ff);
    chk({25'h0, cal_value_o}, 32'h7f);
    chk({31'h0, cal_direction_o}, 32'h1);
    // Power-on reset clears only its own two output bits
    por_rst_i <= 1'b1;
    cyc(2);
    por_rst_i <= 1'b0;
    rdchk(BKR_OUT_CTL_OFS, 32'h837f);
    rdchk(ofs(41), dv(41));
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    rdchk(BKR_OUT_CTL_OFS, 32'h837f);
    rdchk(ofs(0), dv(0));
    // Alarm and second pulses, then priority over the calibration clock
    wr(BKR_OUT_CTL_OFS, 32'h0100);
    rtc_alarm_i <= 1'b1;
    cyc(4);
    chk({tamper_pin_oe_o, tamper_pin_o}, 32'h3);
    rtc_alarm_i <= 1'b0;
    rtc_second_i <= 1'b1;
    cyc(4);
    chk({tamper_pin_oe_o, tamper_pin_o}, 32'h2);
    wr(BKR_OUT_CTL_OFS, 32'h0380);
    cyc(4);
    chk({31'h0, tamper_pin_o}, 32'h1);
    run_rtc(tog);
    chk(32'(tog), 32'h0);
    rtc_second_i <= 1'b0;
    wr(BKR_OUT_CTL_OFS, 32'h0080);
    cyc(6);
    run_rtc(tog);
    chk(32'(tog), 32'(32 / DIV));
    wr(BKR_OUT_CTL_OFS, 32'h4080);
    cyc(6);
    run_rtc(tog);
    chk(32'(tog), 32'd32);
    // Active-high tamper with interrupt enabled
    wr(BKR_TAMP_CS_OFS, 32'h4);
    wr(BKR_PIN_CTL_OFS, 32'h1);
    cyc(1);
    chk({31'h0, tamper_pin_oe_o}, 32'h0);
    tamper_pin_i <= 1'b1;
    wait_for(1);
    cyc(1);
    chk({31'h0, tamper_irq_o}, 32'h1);
    cyc(3);
    chk({31'h0, tamper_event_o}, 32'h0);
    rdchk(BKR_TAMP_CS_OFS, 32'h0304);
    rdchk(ofs(0), 32'h0);
    rdchk(ofs(41), 32'h0);
    wr(BKR_TAMP_CS_OFS, 32'h5);
    rdchk(BKR_TAMP_CS_OFS, 32'h0204);
    wr(BKR_TAMP_CS_OFS, 32'h6);
    rdchk(BKR_TAMP_CS_OFS, 32'h0004);
    // Active-low, pin already active before detection is enabled
    wr(BKR_PIN_CTL_OFS, 32'h2);
    tamper_pin_i <= 1'b0;
    cyc(6);
    rdchk(BKR_TAMP_CS_OFS, 32'h0004);
    wr(BKR_PIN_CTL_OFS, 32'h3);
    wait_for(1);
    cyc(1);
    rdchk(BKR_TAMP_CS_OFS, 32'h0304);
    wr(BKR_TAMP_CS_OFS, 32'h0);
    rdchk(BKR_TAMP_CS_OFS, 32'h0100);
    // Interrupt enable lost on standby wake-up and on system reset
    wr(BKR_TAMP_CS_OFS, 32'h4);
    stby_wake_i <= 1'b1;
    cyc(1);
    stby_wake_i <= 1'b0;
    rdchk(BKR_TAMP_CS_OFS, 32'h0100);
    wr(BKR_TAMP_CS_OFS, 32'h4);
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    rdchk(BKR_TAMP_CS_OFS, 32'h0100);
    // New event with interrupt disabled sets only the event flag
    wr(BKR_TAMP_CS_OFS, 32'h1);
    tamper_pin_i <= 1'b1;
    cyc(4);
    tamper_pin_i <= 1'b0;
    wait_for(1);
    cyc(1);
    rdchk(BKR_TAMP_CS_OFS, 32'h0100);
    // Backup-domain reset clears data, its fields and the flags
    wr(BKR_PIN_CTL_OFS, 32'h0);
    wr(ofs(0), 32'h1234);
    bkp_rst_i <= 1'b1;
    cyc(2);
    bkp_rst_i <= 1'b0;
    rdchk(ofs(0), 32'h0);
    rdchk(BKR_OUT_CTL_OFS, 32'h4080);
    rdchk(BKR_TAMP_CS_OFS, 32'h0);
    final_report();
  end
endmodule

`default_nettype wire
